/* File: src/dma_command_mode_control.sv */
`default_nettype none

// Summary of operation
// - Command bit 7 sets acknowledge polarity
// - Command bit 6 sets request polarity
// - Bit 4 clear: fixed priority, channel 0 first
// - Bit 4 set: granted channel becomes lowest
// - Word takes four cycles, three compressed
// - Compressed: strobes and terminal count earlier
// - Bit 2 set: no new DMA cycles
// - Bit 1 set: channel 0 address held
// - Bit 0 set: channels 0,1 memory-to-memory
// - Request write with bit 2 raises request
// - Software requests ignore the mask
// - Mask write changes only selected channel
// - Mask write bit 2 sets, clear clears
// - Mode bits 7:6 select transfer mode
// - Mode bit 5 selects address direction
// - Autoinit reloads base values at terminal count
// - Autoinit channel not masked at terminal count
// - Mode bits 3:2 select transfer type
// - Mode write bits 1:0 pick channel
// - Mode reads walk through all channels
// - Read walk clear restarts at channel 0
// - Mode readback selector reads as 11
// - Mask bits 3:0, cleared on reset
module dma_command_mode_control
   import dma_ctl_pkg::*;
(
   input  wire logic       mclk,         // 200 MHz controller clock
   input  wire logic       rstn,         // Asynchronous reset, active low
   input  wire io_req_s    io_req,       // Host I/O access, one-cycle strobes
   output logic [7:0]      io_rdata,     // Read data, valid the cycle after io_req.rd
   input  wire logic [3:0] dreq_pin,     // Peripheral request pins
   input  wire logic [3:0] count_last,   // Channel word count at its last word
   output logic [3:0]      dack_pin,     // Acknowledge pins, polarity per command
   output xfer_cmd_s       xfer_cmd,     // Transfer command strobes
   output logic            tc_out,       // Terminal count, high active
   output logic [1:0]      xfer_chan,    // Channel being served
   output logic            addr_inc,     // Step address up, one cycle
   output logic            addr_dec,     // Step address down, one cycle
   output logic            addr_reload,  // Copy base into current, one cycle
   output logic            dma_busy      // Sequencer owns the bus
);

   // Registered state and its next value
   ctl_state_s state_r;
   ctl_state_s state_nxt;

   // Reset image of the whole state
   localparam ctl_state_s STATE_RST = '{
      cmd:      CMD_RST,
      mask:     MASK_RST,
      mode:     {4{MODE_RST}},
      sw_req:   SW_REQ_RST,
      rd_ptr:   2'h0,
      prio_low: 2'h3,
      dreq_s1:  4'h0,
      dreq_s2:  4'h0,
      st:       ST_IDLE,
      chan:     2'h0,
      m2m:      1'b0,
      m2m_dst:  1'b0,
      rdata:    RDATA_RST,
      dack:     DACK_IDLE_RST,
      strobes:  CMD_IDLE_RST,
      tc:       1'b0,
      addr_inc: 1'b0,
      addr_dec: 1'b0,
      reload:   1'b0,
      busy:     1'b0
   };

   // Combinational working values
   logic [3:0] hw_req;      // Synchronised requests at active-high level
   logic [3:0] pend;        // Requests eligible for service
   logic [1:0] base;        // Channel examined first
   logic [1:0] cand;        // Candidate in the priority scan
   logic [1:0] grant;       // Winner of arbitration
   logic       found;       // Some request won
   logic [1:0] xmode;       // Transfer mode of served channel
   logic [1:0] xtype;       // Transfer type of served channel
   logic       word_done;   // Service of this channel finishes
   logic       in_xfer;     // Next state is inside a word transfer
   logic       strobe_on;   // Next state asserts command strobes
   logic [3:0] ack_vec;     // Acknowledge, active high before polarity
   logic [1:0] sel;         // Channel selector from written data
   logic       hold;        // Address hold applies to this word

   // Next-state logic for everything the controller holds
   always_comb
   begin
      state_nxt = state_r;
      hw_req    = 4'h0;
      pend      = 4'h0;
      base      = 2'h0;
      cand      = 2'h0;
      grant     = 2'h0;
      found     = 1'b0;
      word_done = 1'b0;
      in_xfer   = 1'b0;
      strobe_on = 1'b0;
      ack_vec   = 4'h0;
      hold      = 1'b0;
      sel       = io_req.wdata[SEL_HI:SEL_LO];
      xmode     = state_r.mode[state_r.chan][MODE_XFER_HI:MODE_XFER_LO];
      xtype     = state_r.mode[state_r.chan][MODE_TYPE_HI:MODE_TYPE_LO];

      // Two-stage synchroniser on request pins
      state_nxt.dreq_s1 = dreq_pin;
      state_nxt.dreq_s2 = state_r.dreq_s1;

      // Request polarity, then mask only hardware requests
      hw_req = state_r.dreq_s2 ^ {4{state_r.cmd[CMD_REQ_LOW]}};
      pend   = (hw_req & ~state_r.mask) | state_r.sw_req;

      // Priority scan starts after the last granted channel when rotating
      base = state_r.cmd[CMD_ROTATE] ? 2'(state_r.prio_low + 2'h1) : 2'h0;
      for (int i = 3; i >= 0; i--)
      begin
         cand = 2'(base + 2'(i));
         if (pend[cand])
         begin
            grant = cand;
            found = 1'b1;
         end
      end

      // One-cycle pulses drop by default
      state_nxt.tc       = 1'b0;
      state_nxt.addr_inc = 1'b0;
      state_nxt.addr_dec = 1'b0;
      state_nxt.reload   = 1'b0;

      // Transfer sequencer
      case (state_r.st)
         ST_IDLE:
         begin
            // Disabled controller starts nothing
            if (found && !state_r.cmd[CMD_DISABLE])
            begin
               state_nxt.chan     = grant;
               state_nxt.prio_low = grant;
               state_nxt.m2m      = state_r.cmd[CMD_MEM2MEM] && (grant == 2'h0);
               state_nxt.m2m_dst  = 1'b0;
               if (state_r.mode[grant][MODE_XFER_HI:MODE_XFER_LO] == XM_CASCADE
                   && !(state_r.cmd[CMD_MEM2MEM] && (grant == 2'h0)))
                  state_nxt.st = ST_CASCADE;
               else
                  state_nxt.st = ST_T1;
            end
         end
         ST_T1:
         begin
            // Compressed timing drops T2
            state_nxt.st = state_r.cmd[CMD_COMPRESS] ? ST_T3 : ST_T2;
         end
         ST_T2:
         begin
            state_nxt.st = ST_T3;
         end
         ST_T3:
         begin
            state_nxt.st = ST_T4;
         end
         ST_T4:
         begin
            if (state_r.m2m && !state_r.m2m_dst)
            begin
               // Source word read, now write it through channel 1
               state_nxt.chan    = 2'h1;
               state_nxt.m2m_dst = 1'b1;
               state_nxt.st      = ST_T1;
            end
            else
            begin
               // Decide whether this channel keeps the bus
               case (xmode)
                  XM_SINGLE: word_done = 1'b1;
                  XM_BLOCK:  word_done = state_r.tc;
                  XM_DEMAND: word_done = state_r.tc || !pend[state_r.chan];
                  default:   word_done = 1'b1;
               endcase
               if (state_r.m2m)
                  word_done = state_r.tc;
               // Terminal count masks unless autoinitialised
               if (state_r.tc && !state_r.mode[state_r.chan][MODE_AUTO])
                  state_nxt.mask[state_r.chan] = 1'b1;
               if (word_done)
               begin
                  state_nxt.sw_req[state_r.chan] = 1'b0;
                  if (state_r.m2m)
                     state_nxt.sw_req[0] = 1'b0;
               end
               if (word_done || state_r.cmd[CMD_DISABLE])
               begin
                  state_nxt.st  = ST_IDLE;
                  state_nxt.m2m = 1'b0;
               end
               else
               begin
                  if (state_r.m2m)
                     state_nxt.chan = 2'h0;
                  state_nxt.m2m_dst = 1'b0;
                  state_nxt.st      = ST_T1;
               end
            end
         end
         ST_CASCADE:
         begin
            // Acknowledge held until the cascaded master drops its request
            if (!pend[state_r.chan])
            begin
               state_nxt.sw_req[state_r.chan] = 1'b0;
               state_nxt.st = ST_IDLE;
            end
         end
         default:
         begin
            state_nxt.st = ST_IDLE;
         end
      endcase

      // Per-word pulses on entering T4
      if (state_nxt.st == ST_T4)
      begin
         state_nxt.tc = count_last[state_nxt.chan] && !(state_nxt.m2m && !state_nxt.m2m_dst);
         hold = state_r.cmd[CMD_ADDR_HOLD] && (state_nxt.chan == 2'h0);
         if (!hold)
         begin
            state_nxt.addr_dec = state_nxt.mode[state_nxt.chan][MODE_DOWN];
            state_nxt.addr_inc = !state_nxt.mode[state_nxt.chan][MODE_DOWN];
         end
         state_nxt.reload = state_nxt.tc && state_nxt.mode[state_nxt.chan][MODE_AUTO];
      end

      // Host register writes; reserved bits dropped
      if (io_req.wr)
      begin
         case (io_req.addr)
            OFS_COMMAND:
               state_nxt.cmd = io_req.wdata & CMD_WR_MASK;
            OFS_SW_REQ:
               if (io_req.wdata[REQ_SET_BIT])
                  state_nxt.sw_req[sel] = 1'b1;
            OFS_MASK_BIT:
               state_nxt.mask[sel] = io_req.wdata[REQ_SET_BIT];
            OFS_MODE:
               state_nxt.mode[sel] = {io_req.wdata[7:2], 2'h0};
            OFS_MODE_CLR:
               state_nxt.rd_ptr = 2'h0;
            default:
            begin
               state_nxt.rd_ptr = state_nxt.rd_ptr;
            end
         endcase
         // Terminal count masking wins over a clearing mask write
         if (state_r.st == ST_T4 && state_r.tc && !state_r.m2m_dst && !state_r.m2m
             && !state_r.mode[state_r.chan][MODE_AUTO])
            state_nxt.mask[state_r.chan] = 1'b1;
         if (state_r.st == ST_T4 && state_r.tc && state_r.m2m
             && !state_r.mode[state_r.chan][MODE_AUTO])
            state_nxt.mask[state_r.chan] = 1'b1;
      end

      // Host reads: mode walk at its address, zero elsewhere
      if (io_req.rd)
      begin
         if (io_req.addr == OFS_MODE)
         begin
            state_nxt.rdata  = {state_r.mode[state_r.rd_ptr][7:2], MODE_RD_SEL};
            state_nxt.rd_ptr = 2'(state_r.rd_ptr + 2'h1);
         end
         else
            state_nxt.rdata = RDATA_RST;
      end

      // Strobes, acknowledge and busy follow the next state
      in_xfer   = (state_nxt.st == ST_T1) || (state_nxt.st == ST_T2)
                  || (state_nxt.st == ST_T3) || (state_nxt.st == ST_T4);
      strobe_on = (state_nxt.st == ST_T3) || (state_nxt.st == ST_T4);
      state_nxt.strobes = CMD_IDLE_RST;
      if (strobe_on)
      begin
         if (state_nxt.m2m)
         begin
            state_nxt.strobes.mem_rd_n = state_nxt.m2m_dst;
            state_nxt.strobes.mem_wr_n = !state_nxt.m2m_dst;
         end
         else
         begin
            case (state_nxt.mode[state_nxt.chan][MODE_TYPE_HI:MODE_TYPE_LO])
               XT_WRITE:
               begin
                  state_nxt.strobes.io_rd_n  = 1'b0;
                  state_nxt.strobes.mem_wr_n = 1'b0;
               end
               XT_READ:
               begin
                  state_nxt.strobes.mem_rd_n = 1'b0;
                  state_nxt.strobes.io_wr_n  = 1'b0;
               end
               default:
               begin
                  state_nxt.strobes = CMD_IDLE_RST;
               end
            endcase
         end
      end
      if ((in_xfer && !state_nxt.m2m) || state_nxt.st == ST_CASCADE)
         ack_vec[state_nxt.chan] = 1'b1;
      state_nxt.dack = state_nxt.cmd[CMD_ACK_HIGH] ? ack_vec : ~ack_vec;
      state_nxt.busy = in_xfer || (state_nxt.st == ST_CASCADE);
   end

   // State register, cleared by the CPU reset
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         state_r <= STATE_RST;
      else
         state_r <= state_nxt;
   end

   // Outputs straight from the state register
   assign io_rdata    = state_r.rdata;
   assign dack_pin    = state_r.dack;
   assign xfer_cmd    = state_r.strobes;
   assign tc_out      = state_r.tc;
   assign xfer_chan   = state_r.chan;
   assign addr_inc    = state_r.addr_inc;
   assign addr_dec    = state_r.addr_dec;
   assign addr_reload = state_r.reload;
   assign dma_busy    = state_r.busy;

endmodule : dma_command_mode_control
`default_nettype wire

/* File: src/dma_ctl_pkg.sv */
`default_nettype none
package dma_ctl_pkg;

   // Byte-wide I/O register offsets
   localparam logic [3:0] OFS_COMMAND   = 4'h8;  // Command register (write)
   localparam logic [3:0] OFS_SW_REQ    = 4'h9;  // Software request write
   localparam logic [3:0] OFS_MASK_BIT  = 4'ha;  // Single-bit mask write
   localparam logic [3:0] OFS_MODE      = 4'hb;  // Mode write, mode read walk
   localparam logic [3:0] OFS_MODE_CLR  = 4'he;  // Restarts the mode read walk

   // Command register fields
   localparam int CMD_ACK_HIGH  = 7;  // Acknowledge asserted high
   localparam int CMD_REQ_LOW   = 6;  // Request recognised low
   localparam int CMD_ROTATE    = 4;  // Rotating priority
   localparam int CMD_COMPRESS  = 3;  // Compressed timing
   localparam int CMD_DISABLE   = 2;  // Start no DMA cycles
   localparam int CMD_ADDR_HOLD = 1;  // Channel 0 address held
   localparam int CMD_MEM2MEM   = 0;  // Channels 0 and 1 pair up
   localparam logic [7:0] CMD_WR_MASK = 8'hdf;  // Bit 5 reserved, dropped on write

   // Request and mask write fields
   localparam int REQ_SET_BIT = 2;  // Request raise / mask set
   localparam int SEL_HI      = 1;  // Channel selector msb
   localparam int SEL_LO      = 0;  // Channel selector lsb

   // Mode register fields
   localparam int MODE_XFER_HI = 7;
   localparam int MODE_XFER_LO = 6;
   localparam int MODE_DOWN    = 5;  // Address decrements
   localparam int MODE_AUTO    = 4;  // Autoinitialization
   localparam int MODE_TYPE_HI = 3;
   localparam int MODE_TYPE_LO = 2;
   localparam logic [1:0] MODE_RD_SEL = 2'h3;  // Selector field on readback

   // Transfer modes and transfer types
   localparam logic [1:0] XM_DEMAND  = 2'h0;
   localparam logic [1:0] XM_SINGLE  = 2'h1;
   localparam logic [1:0] XM_BLOCK   = 2'h2;
   localparam logic [1:0] XM_CASCADE = 2'h3;
   localparam logic [1:0] XT_VERIFY  = 2'h0;
   localparam logic [1:0] XT_WRITE   = 2'h1;
   localparam logic [1:0] XT_READ    = 2'h2;

   // Reset values
   localparam logic [7:0] CMD_RST      = 8'h00;
   localparam logic [3:0] MASK_RST     = 4'h0;
   localparam logic [7:0] MODE_RST     = 8'h00;
   localparam logic [3:0] SW_REQ_RST   = 4'h0;
   localparam logic [3:0] DACK_IDLE_RST = 4'hf;  // Active low after reset
   localparam logic [7:0] RDATA_RST    = 8'h00;

   // Transfer sequencer states; T2 is skipped under compressed timing
   typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_T3, ST_T4, ST_CASCADE} xfer_state_e;

   // Host I/O request group
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } io_req_s;

   // Transfer command strobes, all active low
   typedef struct packed {
      logic io_rd_n;
      logic io_wr_n;
      logic mem_rd_n;
      logic mem_wr_n;
   } xfer_cmd_s;

   localparam xfer_cmd_s CMD_IDLE_RST = 4'hf;

   // Whole state of the controller
   typedef struct packed {
      logic [7:0]      cmd;
      logic [3:0]      mask;
      logic [3:0][7:0] mode;
      logic [3:0]      sw_req;
      logic [1:0]      rd_ptr;
      logic [1:0]      prio_low;
      logic [3:0]      dreq_s1;
      logic [3:0]      dreq_s2;
      xfer_state_e     st;
      logic [1:0]      chan;
      logic            m2m;
      logic            m2m_dst;
      logic [7:0]      rdata;
      logic [3:0]      dack;
      xfer_cmd_s       strobes;
      logic            tc;
      logic            addr_inc;
      logic            addr_dec;
      logic            reload;
      logic            busy;
   } ctl_state_s;

endpackage : dma_ctl_pkg
`default_nettype wire

/* File: tb/dma_command_mode_control_tb.sv */
`default_nettype none
module dma_command_mode_control_tb import dma_ctl_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic       mclk;               // 200 MHz clock
   logic       rstn;               // Reset, active low
   io_req_s    io_req;             // Host access
   logic [7:0] io_rdata;           // Read data
   logic [3:0] dreq_pin;           // Request pins
   logic [3:0] count_last;         // Last word flags
   logic [3:0] dack_pin;           // Acknowledge pins
   xfer_cmd_s  xfer_cmd;           // Transfer strobes
   logic       tc_out, addr_inc, addr_dec, addr_reload, dma_busy;
   logic [1:0] xfer_chan;          // Channel served
   logic [3:0] want;               // Peripheral request starts
   logic       req_low, ack_high;  // Polarity used by peripherals
   int         errors = 0;
   int         check_count = 0;
   int         cyc = 0;            // Cycle count for hang guard
   logic [7:0] rv;                 // Last read value
   logic [7:0] mv [4] = '{8'h40, 8'h41, 8'h46, 8'h7b};  // Mode per channel
   dma_command_mode_control dut (.mclk(mclk), .rstn(rstn), .io_req(io_req),
      .io_rdata(io_rdata), .dreq_pin(dreq_pin), .count_last(count_last),
      .dack_pin(dack_pin), .xfer_cmd(xfer_cmd), .tc_out(tc_out), .xfer_chan(xfer_chan),
      .addr_inc(addr_inc), .addr_dec(addr_dec), .addr_reload(addr_reload),
      .dma_busy(dma_busy));
   dma_periph_model periph (.mclk(mclk), .rstn(rstn), .want(want), .req_low(req_low),
      .ack_high(ack_high), .dack_pin(dack_pin), .dreq_pin(dreq_pin));
   // Clock
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Hang guard
   always @(posedge mclk)
   begin
      cyc = cyc + 1;
      if (cyc == 6000)
      begin
         errors = errors + 1;
         conclude();
      end
   end
   task automatic conclude();
      $display("Checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // Host write and read, one-cycle strobes
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      io_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      io_req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      io_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      io_req.rd <= 1'b0;
      #1 rv = io_rdata;
   endtask : rd
   task automatic raise(input logic [3:0] m);
      @(posedge mclk);
      want <= m;
      @(posedge mclk);
      want <= 4'h0;
   endtask : raise
   // No cycle may start for n cycles
   task automatic quiet(input int n);
      repeat (n) @(posedge mclk) #1 chk("busy", 8'h00, {7'h0, dma_busy});
   endtask : quiet
   // One word: grant, strobes and pulses in the last cycle, optional idle after
   task automatic word(input logic [1:0] ch, input logic [3:0] dk, input int len,
                       input logic [3:0] st, input logic [3:0] pul, input bit more);
      int n;
      n = 0;
      do
         @(posedge mclk) #1 n++;
      while (dma_busy !== 1'b1 && n < 40);
      chk("dack", {4'h0, dk}, {4'h0, dack_pin});
      chk("chan", {6'h0, ch}, {6'h0, xfer_chan});
      repeat (len - 1) @(posedge mclk);
      #1 chk("strobes", {4'h0, st}, {4'h0, xfer_cmd});
      chk("pulses", {4'h0, pul}, {4'h0, addr_inc, addr_dec, tc_out, addr_reload});
      if (!more)
         @(posedge mclk) #1 chk("end", 8'h00, {7'h0, dma_busy});
   endtask : word
   task automatic t_reset();
      @(posedge mclk) #1 chk("dack", 8'h0f, {4'h0, dack_pin});
      chk("strobes", 8'h0f, {4'h0, xfer_cmd});
      rd(OFS_MODE);
      chk("mode", 8'h03, rv);
      rd(OFS_COMMAND);
      chk("unlisted", 8'h00, rv);
   endtask : t_reset
   task automatic t_modes();
      for (int k = 0; k < 4; k++)
      begin
         wr(OFS_MODE, {2'(k), 6'h00});
         wr(OFS_MODE_CLR, 8'h00);
         rd(OFS_MODE);
         chk("mode", {2'(k), 6'h03}, rv);
      end
      for (int i = 0; i < 4; i++) wr(OFS_MODE, mv[i]);
      rd(OFS_MODE);
      wr(OFS_MODE_CLR, 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         rd(OFS_MODE);
         chk("walk", {mv[i % 4][7:2], 2'h3}, rv);
      end
   endtask : t_modes
   task automatic t_single();
      @(posedge mclk) count_last <= 4'h4;
      raise(4'h4);
      word(2'h2, 4'hb, 4, 4'h6, 4'ha, 1'b0);
      raise(4'h4);
      wr(OFS_SW_REQ, 8'h03);
      quiet(10);
      wr(OFS_SW_REQ, 8'h06);
      word(2'h2, 4'hb, 4, 4'h6, 4'ha, 1'b0);
      @(posedge mclk) count_last <= 4'h0;
   endtask : t_single
   task automatic t_comp();
      wr(OFS_COMMAND, 8'h08);
      count_last <= 4'h8;
      for (int i = 0; i < 2; i++)
      begin
         raise(4'h8);
         word(2'h3, 4'h7, 3, 4'h9, 4'h7, 1'b0);
      end
      @(posedge mclk) count_last <= 4'h0;
   endtask : t_comp
   task automatic t_prio();
      wr(OFS_COMMAND, 8'h00);
      raise(4'ha);
      word(2'h1, 4'hd, 4, 4'hf, 4'h8, 1'b0);
      word(2'h3, 4'h7, 4, 4'h9, 4'h4, 1'b0);
   endtask : t_prio
   task automatic t_rotate();
      wr(OFS_COMMAND, 8'hd4);
      @(posedge mclk);
      req_low <= 1'b1;
      ack_high <= 1'b1;
      raise(4'h2);
      quiet(8);
      wr(OFS_COMMAND, 8'hd0);
      word(2'h1, 4'h2, 4, 4'hf, 4'h8, 1'b0);
      raise(4'h9);
      word(2'h3, 4'h8, 4, 4'h9, 4'h4, 1'b0);
      word(2'h0, 4'h1, 4, 4'hf, 4'h8, 1'b0);
   endtask : t_rotate
   task automatic t_mask();
      wr(OFS_MASK_BIT, 8'h05);
      raise(4'he);
      word(2'h3, 4'h8, 4, 4'h9, 4'h4, 1'b0);
      quiet(8);
      wr(OFS_MASK_BIT, 8'h01);
      word(2'h1, 4'h2, 4, 4'hf, 4'h8, 1'b0);
      quiet(8);
   endtask : t_mask
   task automatic t_m2m();
      @(posedge mclk) count_last <= 4'h2;
      wr(OFS_COMMAND, 8'hc3);
      wr(OFS_SW_REQ, 8'h04);
      word(2'h0, 4'h0, 4, 4'hd, 4'h0, 1'b1);
      word(2'h1, 4'h0, 4, 4'he, 4'ha, 1'b0);
      @(posedge mclk) count_last <= 4'h0;
   endtask : t_m2m
   // Block mode keeps the bus until terminal count
   task automatic t_block();
      wr(OFS_MODE, 8'h86);
      wr(OFS_SW_REQ, 8'h06);
      word(2'h2, 4'h4, 4, 4'h6, 4'h8, 1'b1);
      @(posedge mclk) count_last <= 4'h4;
      repeat (3) @(posedge mclk);
      #1 chk("strobes", 8'h06, {4'h0, xfer_cmd});
      chk("pulses", 8'h0a, {4'h0, addr_inc, addr_dec, tc_out, addr_reload});
      @(posedge mclk) #1 chk("end", 8'h00, {7'h0, dma_busy});
      @(posedge mclk) count_last <= 4'h0;
   endtask : t_block
   // Cascade holds acknowledge, no strobes, until the request drops
   task automatic t_cascade();
      wr(OFS_MODE, 8'hc3);
      raise(4'h8);
      word(2'h3, 4'h8, 3, 4'hf, 4'h0, 1'b0);
   endtask : t_cascade
   // Main sequence
   initial
   begin
      rstn = 1'b0;
      io_req = '0;
      count_last = 4'h0;
      want = 4'h0;
      req_low = 1'b0;
      ack_high = 1'b0;
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      t_reset();
      t_modes();
      t_single();
      t_comp();
      t_prio();
      t_rotate();
      t_mask();
      t_m2m();
      t_block();
      t_cascade();
      conclude();
   end
endmodule : dma_command_mode_control_tb
`default_nettype wire

/* File: tb/dma_ctl_properties.sv */
`default_nettype none
module dma_ctl_properties
   import dma_ctl_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rstn,
   input wire io_req_s    io_req,
   input wire logic [7:0] io_rdata,
   input wire logic [3:0] dreq_pin,
   input wire logic [3:0] count_last,
   input wire logic [3:0] dack_pin,
   input wire xfer_cmd_s  xfer_cmd,
   input wire logic       tc_out,
   input wire logic [1:0] xfer_chan,
   input wire logic       addr_inc,
   input wire logic       addr_dec,
   input wire logic       addr_reload,
   input wire logic       dma_busy
);
   logic [7:0] cmd_r;  // Command shadow
   logic [2:0] ph_r;   // Busy cycles so far in this word
   logic       end_w;  // Last cycle of a word
   assign end_w = addr_inc | addr_dec | tc_out;
   // Shadow command writes, count word phase
   always_ff @(posedge mclk or negedge rstn)
      if (!rstn)
      begin
         cmd_r <= CMD_RST;
         ph_r  <= 3'h0;
      end
      else
      begin
         if (io_req.wr && io_req.addr == OFS_COMMAND)
            cmd_r <= io_req.wdata & CMD_WR_MASK;
         ph_r <= (dma_busy && !end_w) ? ph_r + 3'h1 : 3'h0;
      end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence s_start; $rose(dma_busy); endsequence
   sequence s_mode_rd; io_req.rd && io_req.addr == OFS_MODE; endsequence
   property p_ack_idle;
      !dma_busy && $stable(cmd_r) |-> dack_pin == {4{~cmd_r[CMD_ACK_HIGH]}};
   endproperty
   a_ack_idle: assert property (p_ack_idle)
      else $error("acknowledge not idle");
   property p_ack_grant;
      s_start ##0 !cmd_r[CMD_MEM2MEM] |-> dack_pin[xfer_chan] == cmd_r[CMD_ACK_HIGH];
   endproperty
   a_ack_grant: assert property (p_ack_grant)
      else $error("acknowledge level wrong");
   property p_word_len;
      end_w && !cmd_r[CMD_MEM2MEM] |-> ph_r == (cmd_r[CMD_COMPRESS] ? 3'h2 : 3'h3);
   endproperty
   a_word_len: assert property (p_word_len)
      else $error("word length wrong");
   property p_late_strobe;
      s_start ##0 !cmd_r[CMD_COMPRESS] |-> (xfer_cmd == CMD_IDLE_RST)[*2];
   endproperty
   a_late_strobe: assert property (p_late_strobe)
      else $error("strobe too early");
   property p_disable; cmd_r[CMD_DISABLE] && !dma_busy |=> !dma_busy; endproperty
   a_disable: assert property (p_disable)
      else $error("cycle started while disabled");
   property p_hold;
      cmd_r[CMD_ADDR_HOLD] && xfer_chan == 2'h0 |-> !addr_inc && !addr_dec;
   endproperty
   a_hold: assert property (p_hold)
      else $error("held address stepped");
   property p_dir; !(addr_inc && addr_dec); endproperty
   a_dir: assert property (p_dir)
      else $error("both directions");
   property p_reload; addr_reload |-> tc_out; endproperty
   a_reload: assert property (p_reload)
      else $error("reload without terminal count");
   property p_mode_rd; s_mode_rd |=> io_rdata[1:0] == MODE_RD_SEL; endproperty
   a_mode_rd: assert property (p_mode_rd)
      else $error("mode selector not 11");
   property p_other_rd; io_req.rd && io_req.addr != OFS_MODE |=> io_rdata == RDATA_RST;
   endproperty
   a_other_rd: assert property (p_other_rd)
      else $error("unlisted read not zero");
   property p_rd_stands; !io_req.rd |=> $stable(io_rdata); endproperty
   a_rd_stands: assert property (p_rd_stands)
      else $error("read data moved");
endmodule : dma_ctl_properties
bind dma_command_mode_control dma_ctl_properties u_props (.mclk(mclk), .rstn(rstn),
   .io_req(io_req), .io_rdata(io_rdata), .dreq_pin(dreq_pin), .count_last(count_last),
   .dack_pin(dack_pin), .xfer_cmd(xfer_cmd), .tc_out(tc_out), .xfer_chan(xfer_chan),
   .addr_inc(addr_inc), .addr_dec(addr_dec), .addr_reload(addr_reload), .dma_busy(dma_busy));
`default_nettype wire

/* File: tb/dma_periph_model.sv */
`default_nettype none
module dma_periph_model
(
   input  wire logic       mclk,      // Controller clock
   input  wire logic       rstn,      // Reset, active low
   input  wire logic [3:0] want,      // One-cycle request starts
   input  wire logic       req_low,   // Request pins active low
   input  wire logic       ack_high,  // Acknowledge active high
   input  wire logic [3:0] dack_pin,  // Acknowledge from block
   output logic      [3:0] dreq_pin   // Request pins to block
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] pend_r;  // Requests awaiting service
   logic [3:0] ack_w;   // Acknowledge seen active
   assign ack_w = dack_pin ^ {4{~ack_high}};
   // Hold each request until its acknowledge comes
   always_ff @(posedge mclk or negedge rstn)
      if (!rstn)
         pend_r <= 4'h0;
      else
         pend_r <= (pend_r | want) & ~ack_w;
   // Drop at once on acknowledge, drive the active level
   assign dreq_pin = (pend_r & ~ack_w) ^ {4{req_low}};
endmodule : dma_periph_model
`default_nettype wire
